// file: verilog/fms_pkg.sv
// Constants and types for the two-wire serial memory target
package fms_pkg;
    localparam int FMS_ADDR_W = 14;
    localparam int FMS_DEPTH = 16384;
    localparam logic [3:0] FMS_TYPE_CODE = 4'h6; // Device type code, value arbitrary
    localparam logic [3:0] FMS_BIT_LAST = 4'h7;
    localparam logic [3:0] FMS_BIT_ACK = 4'h8;
    localparam logic [3:0] FMS_BIT_ZERO = 4'h0;
    localparam logic [FMS_ADDR_W-1:0] FMS_ADDR_ZERO = 14'h0000;
    localparam logic [FMS_ADDR_W-1:0] FMS_ADDR_ONE = 14'h0001;
    typedef enum logic [2:0] {
        FMS_IDLE,
        FMS_HDR,
        FMS_ADDR_HI,
        FMS_ADDR_LO,
        FMS_WDATA,
        FMS_RDATA
    } fms_state_t;
endpackage

// file: verilog/fms_slave.sv
// Two-wire serial memory target: link logic on the serial clock, 16K x 8 array
`timescale 1ns/1ps
module fms_slave
    import fms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_inhibit,
    output logic busy
);
    // Reset crosses into the link domain through two flops
    logic rst_l1;
    logic rst_l2;
    always_ff @(posedge scl_clk) begin
        rst_l1 <= nrst;
        rst_l2 <= rst_l1;
    end

    // Start and stop detection: data edges while the clock is high
    logic start_tgl;
    logic stop_tgl;
    logic start_seen;
    logic start_ack;
    // Toggles cleared by system reset so both sides agree after it
    always_ff @(negedge sda_in or negedge nrst) begin
        if (!nrst) begin
            start_tgl <= 1'b0;
        end else if (scl_clk) begin
            start_tgl <= ~start_tgl;
        end
    end
    always_ff @(posedge sda_in or negedge nrst) begin
        if (!nrst) begin
            stop_tgl <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl <= ~stop_tgl;
        end
    end
    assign start_seen = start_tgl ^ start_ack;

    // Stop synchronised into the link domain and pulled to standby there
    logic stop_s1;
    logic stop_s2;
    logic stop_ack;
    always_ff @(posedge scl_clk) begin
        stop_s1 <= stop_tgl;
        stop_s2 <= stop_s1;
    end

    // Strap and write-inhibit pins pass two flops before the link logic reads them
    logic wi_s1;
    logic wi_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    always_ff @(posedge scl_clk) begin
        wi_s1 <= write_inhibit;
        wi_s2 <= wi_s1;
        sel_s1 <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
        sel_s2 <= sel_s1;
    end

    // Memory array and address counter
    logic [7:0] mem [0:FMS_DEPTH-1];
    logic [FMS_ADDR_W-1:0] addr;
    fms_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic is_read;
    logic matched;
    logic ack_ok;
    logic [7:0] hdr;

    function automatic logic [FMS_ADDR_W-1:0] inc_addr(input logic [FMS_ADDR_W-1:0] a);
        inc_addr = a + FMS_ADDR_ONE;
    endfunction

    // Header decode: type code in the top nibble, strap code below it
    function automatic logic hdr_match(input logic [7:0] h, input logic [2:0] s);
        hdr_match = (h[7:4] == FMS_TYPE_CODE) && (h[3:1] == s);
    endfunction

    assign hdr = {shreg[6:0], sda_in};

    // Receive side: sample on rising clock
    always_ff @(posedge scl_clk) begin
        if (!rst_l2) begin
            state <= FMS_IDLE;
            bitcnt <= FMS_BIT_ZERO;
            shreg <= 8'h00;
            is_read <= 1'b0;
            matched <= 1'b0;
            ack_ok <= 1'b0;
            start_ack <= start_tgl;
            stop_ack <= stop_s2;
        end else if (stop_s2 != stop_ack) begin
            stop_ack <= stop_s2;
            state <= FMS_IDLE;
            bitcnt <= FMS_BIT_ZERO;
        end else if (start_seen) begin
            start_ack <= start_tgl;
            state <= FMS_HDR;
            bitcnt <= FMS_BIT_ZERO + 4'h1;
            shreg <= {7'h00, sda_in};
        end else if (state != FMS_IDLE) begin
            if (bitcnt == FMS_BIT_ACK) begin
                bitcnt <= FMS_BIT_ZERO;
                if (state == FMS_RDATA) begin
                    // Counter moves past the byte just sent, acked or not
                    addr <= inc_addr(addr);
                    if (sda_in) begin
                        state <= FMS_IDLE;
                    end
                end else if (!matched) begin
                    state <= FMS_IDLE;
                end else if (state == FMS_HDR) begin
                    // Leave the header only after its own acknowledge bit
                    state <= is_read ? FMS_RDATA : FMS_ADDR_HI;
                end
            end else begin
                bitcnt <= bitcnt + 4'h1;
                shreg <= hdr;
                if (bitcnt == FMS_BIT_LAST) begin
                    unique case (state)
                        FMS_HDR: begin
                            matched <= hdr_match(hdr, sel_s2);
                            is_read <= hdr[0];
                        end
                        FMS_ADDR_HI: begin
                            addr[13:8] <= hdr[5:0];
                            state <= FMS_ADDR_LO;
                        end
                        FMS_ADDR_LO: begin
                            addr[7:0] <= hdr;
                            state <= FMS_WDATA;
                        end
                        FMS_WDATA: begin
                            if (!wi_s2) begin
                                mem[addr] <= hdr;
                            end
                            addr <= inc_addr(addr);
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Transmit side: change output after the falling clock
    logic [7:0] txbyte;
    always_ff @(negedge scl_clk) begin
        if (!rst_l2) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            txbyte <= 8'h00;
        end else if (state == FMS_IDLE) begin
            sda_oe <= 1'b0;
        end else if (bitcnt == FMS_BIT_ACK) begin
            sda_out <= 1'b0;
            sda_oe <= (state != FMS_RDATA) && matched;
        end else if (state == FMS_RDATA && matched) begin
            if (bitcnt == FMS_BIT_ZERO) begin
                txbyte <= {mem[addr][6:0], 1'b0};
                sda_out <= mem[addr][7];
                sda_oe <= ~mem[addr][7];
            end else begin
                txbyte <= {txbyte[6:0], 1'b0};
                sda_out <= txbyte[7];
                sda_oe <= ~txbyte[7];
            end
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // Activity flag handed to the system clock domain
    logic act_l;
    logic act_s1;
    logic act_s2;
    always_ff @(posedge scl_clk) begin
        act_l <= (state != FMS_IDLE);
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
            busy <= 1'b0;
        end else begin
            act_s1 <= act_l;
            act_s2 <= act_s1;
            busy <= act_s2;
        end
    end

    // Checks on the link side
    AST_MISMATCH_IDLE: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (bitcnt == FMS_BIT_ACK && !matched && state != FMS_RDATA && !start_seen
         && stop_s2 == stop_ack) |=> state == FMS_IDLE)
        else $error("mismatch did not return to standby");
    AST_NACK_IDLE: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (state == FMS_RDATA && bitcnt == FMS_BIT_ACK && sda_in && !start_seen
         && stop_s2 == stop_ack) |=> state == FMS_IDLE)
        else $error("no release after nack");
    AST_STOP_IDLE: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (stop_s2 != stop_ack) |=> state == FMS_IDLE)
        else $error("stop did not abort");
    AST_NO_HIGH: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        sda_oe |-> !sda_out)
        else $error("data driven high");
    AST_RD_INC: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (state == FMS_RDATA && bitcnt == FMS_BIT_ACK && !sda_in && !start_seen
         && stop_s2 == stop_ack) |=> addr == inc_addr($past(addr)))
        else $error("read address not advanced");
    AST_HDR_DIR: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (state == FMS_HDR && bitcnt == FMS_BIT_LAST && !start_seen
         && stop_s2 == stop_ack) |=> is_read == $past(sda_in))
        else $error("direction bit misread");

    // No start or stop pending at this edge
    sequence s_quiet;
        !start_seen && stop_s2 == stop_ack;
    endsequence
    // Last bit of a byte in a given phase, or the matched header's acknowledge bit
    sequence s_last_hdr;
        state == FMS_HDR && bitcnt == FMS_BIT_LAST;
    endsequence
    sequence s_last_wr;
        state == FMS_WDATA && bitcnt == FMS_BIT_LAST;
    endsequence
    sequence s_last_ahi;
        state == FMS_ADDR_HI && bitcnt == FMS_BIT_LAST;
    endsequence
    sequence s_ack_hdr;
        state == FMS_HDR && bitcnt == FMS_BIT_ACK && matched;
    endsequence

    // Receiver pulls data low on the ninth clock of every accepted byte
    AST_ACK_DRIVEN: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (state != FMS_IDLE && state != FMS_RDATA && bitcnt == FMS_BIT_ACK && matched)
        |-> sda_oe)
        else $error("acknowledge not driven");
    // Sender lets go of data while the master answers
    AST_RD_RELEASE: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        (state == FMS_RDATA && bitcnt == FMS_BIT_ACK) |-> !sda_oe)
        else $error("data held during master answer");
    // Header decode stores the match result
    AST_HDR_MATCH: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_last_hdr ##0 s_quiet |=> matched == hdr_match($past(hdr), sel_s2))
        else $error("header match wrong");
    // Matched header moves on by its direction bit
    AST_HDR_NEXT: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_ack_hdr ##0 s_quiet |=> state == (is_read ? FMS_RDATA : FMS_ADDR_HI))
        else $error("header phase not left");
    // High address byte lands in the top of the counter
    AST_ADDR_HI: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_last_ahi ##0 s_quiet |=> addr[13:8] == $past(hdr[5:0]))
        else $error("high address byte not loaded");
    // Write byte commits at once when not inhibited
    AST_WR_STORE: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_last_wr ##0 s_quiet ##0 !wi_s2 |=> mem[$past(addr)] == $past(hdr))
        else $error("write not committed");
    // Inhibited write leaves the array alone
    AST_WR_BLOCK: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_last_wr ##0 s_quiet ##0 wi_s2 |=> mem[$past(addr)] == $past(mem[addr]))
        else $error("inhibited write changed array");
    // Write counter advances and wraps
    AST_WR_INC: assert property (@(posedge scl_clk) disable iff (!rst_l2)
        s_last_wr ##0 s_quiet |=> addr == inc_addr($past(addr)))
        else $error("write address not advanced");
endmodule // fms_slave

// file: dv/fms_master.sv
// Two-wire bus master model: makes the serial clock, pulls data open-drain
`timescale 1ns/1ps
module fms_master (
    output logic scl_clk,
    output logic mst_oe,
    input wire logic sda
);
    // Bus idles released with the clock high
    initial begin
        scl_clk = 1'b1;
        mst_oe = 1'b0;
    end
    // One bit of 48 ns: pull low for zero, release for one, sample while high
    task automatic bit_io(input logic b, output logic q);
        scl_clk = 1'b0;
        #12 mst_oe = ~b;
        #12 scl_clk = 1'b1;
        #12 q = sda;
        #12;
    endtask
    // Four clock pulses with data released, enough for a stop to settle
    task automatic idle;
        repeat (4) begin
            scl_clk = 1'b0;
            #24 scl_clk = 1'b1;
            #24;
        end
    endtask
    // Data falls while the clock is high
    task automatic start_c;
        scl_clk = 1'b0;
        #12 mst_oe = 1'b0;
        #12 scl_clk = 1'b1;
        #12 mst_oe = 1'b1;
        #12;
    endtask
    // Data rises while the clock is high, then idle pulses let it land
    task automatic stop_c;
        scl_clk = 1'b0;
        #12 mst_oe = 1'b1;
        #12 scl_clk = 1'b1;
        #12 mst_oe = 1'b0;
        #12;
        idle();
    endtask
    // Eight bits MSB first, then the ninth clock; rd leaves data to the target
    task automatic byte_io(input logic [7:0] d, input logic rd, input logic mack,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(rd | d[i], q[i]);
        bit_io(rd ? mack : 1'b1, ack);
    endtask
endmodule // fms_master

// file: dv/fms_slave_tb.sv
// Self-checking bench for the serial memory target with a bus master model
`timescale 1ns/1ps
module fms_slave_tb;
    import fms_pkg::*;
    typedef struct packed {logic [13:0] a; logic [7:0] d;} fms_row_t;
    localparam fms_row_t ROWS [4] = '{'{14'h0000, 8'h5a}, '{14'h1234, 8'ha5},
                                      '{14'h2ed1, 8'h3c}, '{14'h3ffd, 8'he7}};
    logic clk_sys, nrst, write_inhibit, ack, scl_clk, mst_oe, sda_out, sda_oe, busy;
    logic [2:0] sel;
    logic [7:0] q;
    int n_mismatch, n_tests;
    // Pulled-up data wire
    wire logic sda = !((sda_oe && !sda_out) || mst_oe);
    fms_slave u_fms_slave (.clk_sys(clk_sys), .nrst(nrst), .scl_clk(scl_clk),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]),
        .write_inhibit(write_inhibit), .busy(busy));
    fms_master u_fms_master (.scl_clk(scl_clk), .mst_oe(mst_oe), .sda(sda));
    // System clock, 25 ns
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic close_out;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xb(input logic [7:0] d, input logic rd, input logic mack);
        u_fms_master.byte_io(d, rd, mack, q, ack);
    endtask
    task automatic hdr(input logic [2:0] s, input logic rd);
        u_fms_master.start_c();
        xb({FMS_TYPE_CODE, s, rd}, 1'b0, 1'b1);
    endtask
    // Write header and both address bytes, all acknowledged
    task automatic set_addr(input logic [13:0] a);
        hdr(sel, 1'b0);
        check(ack, 1'b0);
        xb({2'b00, a[13:8]}, 1'b0, 1'b1);
        check(ack, 1'b0);
        xb(a[7:0], 1'b0, 1'b1);
        check(ack, 1'b0);
    endtask
    // Read n bytes, master acks all but the last
    task automatic rd_bytes(input logic [31:0] e, input int n);
        hdr(sel, 1'b1);
        check(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            xb(8'hff, 1'b1, i == n - 1);
            check(q, e[31-8*i -: 8]);
        end
        u_fms_master.stop_c();
    endtask
    // Hang guard
    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end
    initial begin
        nrst = 1'b0;
        write_inhibit = 1'b0;
        sel = 3'h5;
        n_mismatch = 0;
        n_tests = 0;
        u_fms_master.idle();
        @(negedge clk_sys) nrst = 1'b1;
        u_fms_master.idle();
        // Byte write, then random read with repeated start
        foreach (ROWS[i]) begin
            set_addr(ROWS[i].a);
            xb(ROWS[i].d, 1'b0, 1'b1);
            check(ack, 1'b0);
            u_fms_master.stop_c();
            set_addr(ROWS[i].a);
            rd_bytes({ROWS[i].d, 24'h0}, 1);
        end
        repeat (8) @(negedge clk_sys);
        check(busy, 1'b0);
        // Wrong select code, then wrong type code
        hdr(~sel, 1'b0);
        check(ack, 1'b1);
        u_fms_master.stop_c();
        u_fms_master.start_c();
        xb({~FMS_TYPE_CODE, sel, 1'b0}, 1'b0, 1'b1);
        check(ack, 1'b1);
        u_fms_master.stop_c();
        // Page write over the top address, sequential and current reads wrap
        set_addr(14'h3ffe);
        check(busy, 1'b1);
        for (int i = 0; i < 4; i++) begin
            xb(8'hc0 + 8'(i), 1'b0, 1'b1);
            check(ack, 1'b0);
        end
        u_fms_master.stop_c();
        set_addr(14'h3ffe);
        rd_bytes(32'hc0c1c2ff, 3);
        rd_bytes(32'hc3000000, 1);
        // Inhibited write is acknowledged but dropped; reads still work
        @(negedge clk_sys) write_inhibit = 1'b1;
        set_addr(ROWS[1].a);
        xb(8'h00, 1'b0, 1'b1);
        check(ack, 1'b0);
        u_fms_master.stop_c();
        set_addr(ROWS[1].a);
        rd_bytes({ROWS[1].d, 24'h0}, 1);
        @(negedge clk_sys) write_inhibit = 1'b0;
        // Stop in mid-byte abandons the write
        set_addr(ROWS[2].a);
        repeat (4) u_fms_master.bit_io(1'b0, ack);
        u_fms_master.stop_c();
        set_addr(ROWS[2].a);
        rd_bytes({ROWS[2].d, 24'h0}, 1);
        // Reset in mid-transaction
        set_addr(ROWS[3].a);
        @(negedge clk_sys) nrst = 1'b0;
        u_fms_master.idle();
        check({busy, sda_oe}, 2'b00);
        @(negedge clk_sys) nrst = 1'b1;
        u_fms_master.idle();
        set_addr(ROWS[3].a);
        rd_bytes({ROWS[3].d, 24'h0}, 1);
        close_out();
    end
endmodule // fms_slave_tb
